// >>> include/ctp_regs.svh
// Register offsets, field positions, reset values and timing counts of the transmit packer
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

`define CTP_NCH          2
`define CTP_NSIG         4
`define CTP_CLK_NS       50
`define CTP_TICK_NS      1000000
`define CTP_MS_CYCLES    (`CTP_TICK_NS / `CTP_CLK_NS)
`define CTP_DIV_STEPS    6'h21

`define CTP_OFF_MSG      6'h00
`define CTP_OFF_RATE     6'h04
`define CTP_OFF_SCFG     6'h10
`define CTP_OFF_SRES     6'h20
`define CTP_OFF_SOFF     6'h30
`define CTP_OFF_CTRL     12'h100
`define CTP_OFF_STATUS   12'h104

`define CTP_MSG_PGN_LSB  0
`define CTP_MSG_PRIO_LSB 16
`define CTP_MSG_DEST_LSB 24
`define CTP_SCFG_SRC_LSB 0
`define CTP_SCFG_NUM_LSB 2
`define CTP_SCFG_SZ_LSB  4
`define CTP_SCFG_BYT_LSB 8
`define CTP_SCFG_BIT_LSB 12
`define CTP_CTRL_OWN_LSB 0
`define CTP_CTRL_MSK_LSB 8
`define CTP_CTRL_MEN_BIT 16
`define CTP_STAT_CNT_LSB 0
`define CTP_STAT_LVL_LSB 16
`define CTP_STAT_BSY_BIT 19

`define CTP_PGN_RST      16'hFF00
`define CTP_RATE_RST     16'h03E8
`define CTP_PRIO_RST     3'h6
`define CTP_DEST_RST     8'hFE
`define CTP_RES_RST      17'h00001
`define CTP_OFF_RST      32'h00000000
`define CTP_OWN_RST      8'h81
`define CTP_MSK_RST      8'h80
`define CTP_SCALE_LIM    17'h186A0
`define CTP_PDU2_PF      8'hF0

`define CTP_SIZE_NONE    3'h0
`define CTP_SIZE_1BIT    3'h1
`define CTP_SIZE_2BIT    3'h2
`define CTP_SIZE_4BIT    3'h3
`define CTP_SIZE_1BYTE   3'h4
`define CTP_SIZE_2BYTE   3'h5
`define CTP_SIZE_4BYTE   3'h6

`endif

// >>> include/ctp_pkg.sv
// Types shared by the transmit packer
`default_nettype none
package ctp_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_DIV, ST_INS, ST_PUSH} ctp_state_t;
  typedef logic [92:0] ctp_frame_t;
  typedef logic [2:0]  ctp_size_t;
endpackage
`default_nettype wire

// >>> hw/ctp_packer.sv
// Transmit packer: APB setpoints, millisecond scheduler, scaler, payload builder and frame FIFO
//
// The APB register port and the register offsets were chosen for this implementation.
`include "ctp_regs.svh"
`default_nettype none

module ctp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Filling side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  // Draining side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D+1)-1:0]      level
);
  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D + 1);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = level != LW'(D);
  assign out_valid = level != '0;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      level <= level + LW'(push) - LW'(pop);
    end
  end
endmodule

module ctp_packer #(
  parameter int MS_CYCLES = `CTP_MS_CYCLES
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Signal sources, sixteen 32-bit values indexed by {source, instance}
  input  wire logic [511:0]           src_values,
  // Frame output towards the CAN controller
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  output logic [28:0]                 tx_id,
  output logic [63:0]                 tx_data
);
  import ctp_pkg::*;

  localparam int NCH = `CTP_NCH;

  // Setpoints
  logic [15:0]        pgn      [NCH];
  logic [2:0]         prio     [NCH];
  logic [7:0]         dest     [NCH];
  logic [15:0]        rate     [NCH];
  logic [14:0]        sig_cfg  [NCH][`CTP_NSIG];
  logic [16:0]        sig_res  [NCH][`CTP_NSIG];
  logic signed [31:0] sig_off  [NCH][`CTP_NSIG];
  logic [7:0]         own_addr;
  logic [7:0]         mask_src;
  logic               mask_en;

  // APB decode; answer is registered during setup so pready comes from a flip-flop
  wire        setup    = psel && !penable;
  wire        wr_en    = psel && penable && pready && pwrite && !pslverr;
  wire        in_ch    = paddr[11:7] == 5'h00 && paddr[1:0] == 2'h0;
  wire        ch_sel   = paddr[6];
  wire [5:0]  loc      = paddr[5:0];
  wire [1:0]  rsig     = loc[3:2];
  wire [5:0]  kind     = {loc[5:4], 4'h0};
  wire        hit_msg  = in_ch && loc == `CTP_OFF_MSG;
  wire        hit_rate = in_ch && loc == `CTP_OFF_RATE;
  wire        hit_sig  = in_ch && loc[5:4] != 2'h0;
  wire        hit_ctrl = paddr == `CTP_OFF_CTRL;
  wire        hit_stat = paddr == `CTP_OFF_STATUS;
  wire        rd_hit   = hit_msg || hit_rate || hit_sig || hit_ctrl || hit_stat;
  logic [15:0] sent_cnt;
  logic [2:0]  fifo_level;
  ctp_state_t  st;
  wire [31:0] msg_word = {dest[ch_sel], 5'h00, prio[ch_sel], pgn[ch_sel]};
  wire [31:0] sig_word = (kind == `CTP_OFF_SCFG) ? {17'h0, sig_cfg[ch_sel][rsig]} :
                         (kind == `CTP_OFF_SRES) ? {15'h0, sig_res[ch_sel][rsig]} : sig_off[ch_sel][rsig];
  wire [31:0] ctrl_word = {15'h0000, mask_en, mask_src, own_addr};
  wire [31:0] stat_word = {12'h000, st != ST_IDLE, fifo_level, sent_cnt};
  wire [31:0] rd_word  = hit_msg  ? msg_word : hit_rate ? {16'h0000, rate[ch_sel]} :
                         hit_sig  ? sig_word : hit_ctrl ? ctrl_word : hit_stat ? stat_word : 32'h00000000;

  // Scaling constants are clamped on write, so the datapath never sees out-of-range values
  wire signed [31:0] wsig   = pwdata;
  wire signed [31:0] lim_p  = {15'h0000, `CTP_SCALE_LIM};
  wire signed [31:0] lim_n  = -lim_p;
  wire [16:0]        res_cl = (pwdata > {15'h0000, `CTP_SCALE_LIM}) ? `CTP_SCALE_LIM :
                              (pwdata == 32'h00000000) ? `CTP_RES_RST : pwdata[16:0];
  wire [31:0]        off_cl = (wsig > lim_p) ? lim_p : (wsig < lim_n) ? lim_n : wsig;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        prdata  <= rd_word;
        pslverr <= !rd_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      own_addr <= `CTP_OWN_RST;
      mask_src <= `CTP_MSK_RST;
      mask_en  <= 1'b0;
    end
    else if (wr_en && hit_ctrl)
    begin
      own_addr <= pwdata[`CTP_CTRL_OWN_LSB +: 8];
      mask_src <= pwdata[`CTP_CTRL_MSK_LSB +: 8];
      mask_en  <= pwdata[`CTP_CTRL_MEN_BIT];
    end
  end

  // Millisecond tick; the count is a parameter so a bench can shorten it
  logic [31:0] tick_cnt;
  logic        ms_tick;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 32'h00000000;
      ms_tick  <= 1'b0;
    end
    else
    begin
      ms_tick  <= tick_cnt == 32'(MS_CYCLES - 1);
      tick_cnt <= (tick_cnt == 32'(MS_CYCLES - 1)) ? 32'h00000000 : tick_cnt + 32'h00000001;
    end
  end

  // Effective interval: the lowest channel with the same PGN wins
  logic [15:0] eff_rate [NCH];
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      eff_rate[c] = rate[c];
      for (int j = c - 1; j >= 0; j--)
        if (pgn[j] == pgn[c])
          eff_rate[c] = rate[j];
    end
  end

  logic [NCH-1:0] expire;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] take;
  logic [15:0]    tcnt [NCH];

  genvar c, s;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      wire ch_wr = wr_en && in_ch && ch_sel == 1'(c);
      assign expire[c] = ms_tick && eff_rate[c] != 16'h0000 && tcnt[c] >= eff_rate[c] - 16'h0001;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pgn[c]  <= `CTP_PGN_RST + 16'(c);
          prio[c] <= `CTP_PRIO_RST;
          dest[c] <= `CTP_DEST_RST;
          rate[c] <= `CTP_RATE_RST;
          tcnt[c] <= 16'h0000;
        end
        else
        begin
          if (ch_wr && hit_msg)
          begin
            pgn[c]  <= pwdata[`CTP_MSG_PGN_LSB +: 16];
            prio[c] <= pwdata[`CTP_MSG_PRIO_LSB +: 3];
            dest[c] <= pwdata[`CTP_MSG_DEST_LSB +: 8];
          end
          if (ch_wr && hit_rate)
            rate[c] <= pwdata[15:0];
          if (ms_tick)
            tcnt[c] <= expire[c] || eff_rate[c] == 16'h0000 ? 16'h0000 : tcnt[c] + 16'h0001;
        end
      end
      for (s = 0; s < `CTP_NSIG; s++)
      begin : g_sig
        wire s_wr = ch_wr && hit_sig && rsig == 2'(s);
        always_ff @(posedge pclk or negedge presetn)
        begin
          if (!presetn)
          begin
            sig_cfg[c][s] <= 15'h0000;
            sig_res[c][s] <= `CTP_RES_RST;
            sig_off[c][s] <= `CTP_OFF_RST;
          end
          else if (s_wr)
          begin
            if (kind == `CTP_OFF_SCFG)
              sig_cfg[c][s] <= pwdata[14:0];
            if (kind == `CTP_OFF_SRES)
              sig_res[c][s] <= res_cl;
            if (kind == `CTP_OFF_SOFF)
              sig_off[c][s] <= off_cl;
          end
        end
      end
    end
  endgenerate

  // Frame builder
  logic [0:0]  cur_ch;
  logic [1:0]  sidx;
  logic [63:0] payload;
  logic [32:0] quo;
  logic [17:0] rem;
  logic        neg;
  logic [5:0]  div_cnt;
  wire         fifo_in_ready;
  wire         start = st == ST_IDLE && pend != '0;
  wire [0:0]   low_ch = pend[0] ? 1'b0 : 1'b1;
  assign take = start ? (NCH'(1) << low_ch) : '0;

  wire [14:0]        cur_cfg  = sig_cfg[cur_ch][sidx];
  wire [16:0]        cur_res  = sig_res[cur_ch][sidx];
  wire signed [31:0] cur_off  = sig_off[cur_ch][sidx];
  wire [1:0]         cur_src  = cur_cfg[`CTP_SCFG_SRC_LSB +: 2];
  wire [3:0]         cur_slot = {cur_src, cur_cfg[`CTP_SCFG_NUM_LSB +: 2]};
  wire ctp_size_t    cur_size = cur_cfg[`CTP_SCFG_SZ_LSB +: 3];
  wire [2:0]         cur_byte = cur_cfg[`CTP_SCFG_BYT_LSB +: 3];
  wire [2:0]         cur_bit  = cur_cfg[`CTP_SCFG_BIT_LSB +: 3];
  wire [31:0]        cur_val  = src_values[{cur_slot, 5'h00} +: 32];
  wire [5:0]         cur_w    = (cur_size == `CTP_SIZE_1BIT)  ? 6'h01 : (cur_size == `CTP_SIZE_2BIT)  ? 6'h02 :
                                (cur_size == `CTP_SIZE_4BIT)  ? 6'h04 : (cur_size == `CTP_SIZE_1BYTE) ? 6'h08 :
                                (cur_size == `CTP_SIZE_2BYTE) ? 6'h10 : (cur_size == `CTP_SIZE_4BYTE) ? 6'h20 :
                                6'h00;
  wire               sig_used = cur_src != 2'h0 && cur_w != 6'h00;
  wire [63:0]        cur_mask = (64'h1 << cur_w) - 64'h1;
  wire [5:0]         cur_pos  = {cur_byte, 3'h0} + ((cur_w < 6'h08) ? {3'h0, cur_bit} : 6'h00);
  wire signed [32:0] cur_diff = $signed({cur_val[31], cur_val}) - $signed({cur_off[31], cur_off});
  wire [32:0]        cur_mag  = cur_diff[32] ? 33'(-cur_diff) : cur_diff;
  wire [17:0]        rem_sh   = {rem[16:0], quo[32]};
  wire               rem_ge   = rem_sh >= {1'b0, cur_res};
  wire [63:0]        quo_w    = {31'h00000000, quo};
  wire [63:0]        field    = neg ? 64'h0 : (quo_w > cur_mask) ? cur_mask : quo_w;
  wire [63:0]        ins_pay  = (payload & ~(cur_mask << cur_pos)) | (field << cur_pos);

  // Identifier: priority, EDP and DP zero, PF, PS, source address
  wire [7:0]  cur_pf = pgn[cur_ch][15:8];
  wire        pdu1   = cur_pf < `CTP_PDU2_PF;
  wire [7:0]  cur_ps = pdu1 ? dest[cur_ch] : pgn[cur_ch][7:0];
  wire [7:0]  cur_sa = mask_en ? mask_src : own_addr;
  wire [28:0] cur_id = {prio[cur_ch], 2'b00, cur_pf, cur_ps, cur_sa};
  wire ctp_frame_t fifo_in_data = {cur_id, payload};
  wire        fifo_in_valid = st == ST_PUSH;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend <= '0;
    else
      pend <= (pend & ~take) | expire;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st       <= ST_IDLE;
      cur_ch   <= 1'b0;
      sidx     <= 2'h0;
      payload  <= 64'hFFFFFFFFFFFFFFFF;
      quo      <= 33'h0;
      rem      <= 18'h0;
      neg      <= 1'b0;
      div_cnt  <= 6'h00;
      sent_cnt <= 16'h0000;
    end
    else
    begin
      case (st)
        ST_IDLE:
          if (start)
          begin
            cur_ch  <= low_ch;
            sidx    <= 2'h0;
            payload <= 64'hFFFFFFFFFFFFFFFF;
            st      <= ST_LOAD;
          end
        ST_LOAD:
          if (sig_used)
          begin
            quo     <= cur_mag;
            rem     <= 18'h0;
            neg     <= cur_diff[32];
            div_cnt <= `CTP_DIV_STEPS;
            st      <= ST_DIV;
          end
          else if (sidx == 2'h3)
            st <= ST_PUSH;
          else
            sidx <= sidx + 2'h1;
        ST_DIV:
        begin
          rem     <= rem_ge ? rem_sh - {1'b0, cur_res} : rem_sh;
          quo     <= {quo[31:0], rem_ge};
          div_cnt <= div_cnt - 6'h01;
          if (div_cnt == 6'h01)
            st <= ST_INS;
        end
        ST_INS:
        begin
          payload <= ins_pay;
          sidx    <= sidx + 2'h1;
          st      <= (sidx == 2'h3) ? ST_PUSH : ST_LOAD;
        end
        ST_PUSH:
          if (fifo_in_ready)
          begin
            sent_cnt <= sent_cnt + 16'h0001;
            st       <= ST_IDLE;
          end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  // A full FIFO holds the builder in ST_PUSH; later expiries stay pending per channel
  wire             fifo_out_valid;
  wire ctp_frame_t fifo_out_data;
  wire             out_take = fifo_out_valid && (!tx_valid || tx_ready);
  ctp_fifo #(
    .W (93),
    .D (4)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (!tx_valid || tx_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid <= 1'b0;
      tx_id    <= 29'h0;
      tx_data  <= 64'h0;
    end
    else if (!tx_valid || tx_ready)
    begin
      tx_valid <= fifo_out_valid;
      if (out_take)
        {tx_id, tx_data} <= fifo_out_data;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_zero_rate_quiet: assert property (eff_rate[0] == 16'h0000 |-> !expire[0])
    else $error("channel 0 expired with zero interval");
  a_shared_rate_low: assert property (pgn[1] == pgn[0] |-> eff_rate[1] == rate[0]
                                      && (rate[0] != 16'h0000 || !expire[1]))
    else $error("shared PGN did not take lowest channel interval");
  a_pdu1_dest_ins: assert property (fifo_in_valid && pdu1 |-> fifo_in_data[79:72] == dest[cur_ch])
    else $error("PDU1 destination missing");
  a_width_decode: assert property (st == ST_LOAD && cur_size == `CTP_SIZE_4BIT |-> cur_mask == 64'hF)
    else $error("width decode wrong");
  a_unused_skip: assert property (st == ST_LOAD && !sig_used |=> st != ST_DIV)
    else $error("unused signal was scaled");
  a_byte_place: assert property (st == ST_INS |-> cur_pos[5:3] == cur_byte || cur_w < 6'h08)
    else $error("byte position wrong");
  a_bit_ignored: assert property (st == ST_INS && cur_w >= 6'h08 |-> cur_pos[2:0] == 3'h0)
    else $error("bit position used for byte-wide signal");
  a_scale_range: assert property (sig_res[0][0] <= `CTP_SCALE_LIM && sig_res[0][0] != 17'h0
                                  && sig_off[0][0] <= lim_p && sig_off[0][0] >= lim_n)
    else $error("scaling constant out of range");
  a_mask_ignored: assert property (fifo_in_valid && !mask_en |-> fifo_in_data[71:64] == own_addr)
    else $error("mask source used while disabled");
  a_div_steps: assert property (st == ST_LOAD && sig_used |=> st == ST_DIV ##32 st == ST_DIV ##1 st == ST_INS)
    else $error("divide did not take 33 cycles");
  a_sat_field: assert property (st == ST_INS |-> (field & ~cur_mask) == 64'h0)
    else $error("field exceeds width");
  a_fill_ones: assert property (start |=> payload == 64'hFFFFFFFFFFFFFFFF)
    else $error("payload not preset to ones");

  c_frame_sent: cover property (fifo_in_valid && fifo_in_ready);
  c_push_stall: cover property (fifo_in_valid && !fifo_in_ready);
  c_shared_pgn: cover property (pgn[1] == pgn[0] && expire[1]);
  c_pdu1_frame: cover property (fifo_in_valid && pdu1 && st == ST_PUSH);
endmodule

`default_nettype wire

// >>> bench/ctp_sink.sv
// Frame consumer model standing in for the other nodes on the bus
`default_nettype none
module ctp_sink (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Frame stream from the packer
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [28:0] tx_id,
  input  wire logic [63:0] tx_data,
  // Pace: 0 prompt, 1 every other cycle, 2 stalled
  input  wire logic [1:0]  mode,
  // Last accepted frame and its cycle stamp
  output logic [15:0]      frames,
  output logic [31:0]      last_t,
  output logic [28:0]      last_id,
  output logic [63:0]      last_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] now;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      now <= 32'h0;
      tx_ready <= 1'b0;
      frames <= 16'h0;
      last_t <= 32'h0;
      last_id <= 29'h0;
      last_data <= 64'h0;
    end
    else
    begin
      now <= now + 32'h1;
      // A slow node may refuse for a while; it never drops a frame it took
      tx_ready <= (mode == 2'h0) ? 1'b1 : (mode == 2'h1) ? ~tx_ready : 1'b0;
      if (tx_valid && tx_ready)
      begin
        frames <= frames + 16'h1;
        last_t <= now;
        last_id <= tx_id;
        last_data <= tx_data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the transmit packer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] sz, byt, bt; logic [1:0] src; logic [31:0] res, off, val, fld;} ctp_row_t;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0, rd, t0;
  logic         pready, pslverr, tx_valid, tx_ready, err;
  logic [31:0]  prdata, last_t;
  logic [511:0] src_values = '0;
  logic [28:0]  tx_id, last_id;
  logic [63:0]  tx_data, last_data;
  logic [15:0]  frames, n0;
  logic [1:0]   mode = 2'h0;
  int           bad_count = 0, samples_checked = 0;
  ctp_row_t     rows [10] = '{
    '{3'h4, 3'h0, 3'h5, 2'h1, 32'h1, 32'h0, 32'h12, 32'h12},
    '{3'h1, 3'h3, 3'h5, 2'h1, 32'h1, 32'h0, 32'h1, 32'h1},
    '{3'h2, 3'h7, 3'h6, 2'h2, 32'h1, 32'h0, 32'h5, 32'h3},
    '{3'h3, 3'h2, 3'h4, 2'h3, 32'hA, 32'h0, 32'h64, 32'hA},
    '{3'h5, 3'h6, 3'h0, 2'h1, 32'h1, 32'h0, 32'h1234, 32'h1234},
    '{3'h6, 3'h4, 3'h0, 2'h2, 32'h1, 32'h0, 32'h12345678, 32'h12345678},
    '{3'h0, 3'h0, 3'h0, 2'h1, 32'h1, 32'h0, 32'h12, 32'h0},
    '{3'h4, 3'h1, 3'h0, 2'h0, 32'h1, 32'h0, 32'h12, 32'h0},
    '{3'h4, 3'h1, 3'h0, 2'h3, 32'h1, 32'h3C, 32'h32, 32'h0},
    '{3'h4, 3'h1, 3'h0, 2'h1, 32'h0, 32'h7FFFFFFF, 32'h18768, 32'hC8}};
  always #25 pclk = ~pclk;
  ctp_packer #(.MS_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_values(src_values), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data));
  ctp_sink sink (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
    .tx_data(tx_data), .mode(mode), .frames(frames), .last_t(last_t), .last_id(last_id),
    .last_data(last_data));
  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50 && !(pready === 1'b1); i++)
      @(posedge pclk);
    if (i == 50)
    begin
      bad_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_frame();
    int i;
    n0 = frames;
    for (i = 0; i < 3000 && frames == n0; i++)
      @(posedge pclk);
    if (i == 3000)
    begin
      bad_count++;
      test_done();
    end
  endtask
  function automatic logic [63:0] place(ctp_row_t r);
    logic [63:0] d = '1;
    int w, p;
    w = (r.src == 2'h0) ? 0 : (r.sz == 3'h1) ? 1 : (r.sz == 3'h2) ? 2 : (r.sz == 3'h3) ? 4 :
        (r.sz == 3'h4) ? 8 : (r.sz == 3'h5) ? 16 : (r.sz == 3'h6) ? 32 : 0;
    p = r.byt * 8 + ((w < 8) ? r.bt : 0);
    for (int i = 0; i < w; i++)
      if (p + i < 64)
        d[p + i] = r.fld[i];
    return d;
  endfunction
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("tx_valid", tx_valid, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    chk("msg", rd, 32'hFE06FF00);
    apb(1'b0, 12'h004, 32'h0);
    chk("rate", rd, 32'h3E8);
    apb(1'b0, 12'h100, 32'h0);
    chk("ctrl", rd, 32'h8081);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped", {err, rd}, 33'h100000000);
    apb(1'b1, 12'h044, 32'h0);
    foreach (rows[k])
    begin
      // Quiet the channel first so no frame of the old layout is still in flight
      apb(1'b1, 12'h004, 32'h0);
      repeat (200) @(posedge pclk);
      apb(1'b1, 12'h010, {16'h0, 1'b0, rows[k].bt, 1'b0, rows[k].byt, 1'b0, rows[k].sz, 2'h2, rows[k].src});
      apb(1'b1, 12'h020, rows[k].res);
      apb(1'b1, 12'h030, rows[k].off);
      src_values[32 * (rows[k].src * 4 + 2) +: 32] <= rows[k].val;
      apb(1'b1, 12'h004, 32'h2);
      wait_frame();
      chk("payload", last_data, place(rows[k]));
    end
    apb(1'b1, 12'h000, 32'h3303EF00);
    apb(1'b1, 12'h100, 32'h14481);
    wait_frame();
    wait_frame();
    chk("id", last_id, {3'h3, 2'h0, 8'hEF, 8'h33, 8'h44});
    t0 = last_t;
    wait_frame();
    chk("interval", last_t - t0, 64'd40);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h040, 32'h3303EF00);
    apb(1'b1, 12'h044, 32'h2);
    repeat (200) @(posedge pclk);
    n0 = frames;
    repeat (300) @(posedge pclk);
    chk("shared zero", frames, n0);
    apb(1'b1, 12'h004, 32'h1);
    wait_frame();
    mode <= 2'h2;
    repeat (600) @(posedge pclk);
    apb(1'b0, 12'h104, 32'h0);
    chk("fifo full", rd[18:16], 3'h4);
    mode <= 2'h1;
    wait_frame();
    apb(1'b0, 12'h100, 32'h0);
    chk("ctrl set", rd, 32'h00014481);
    // Mid-run reset: setpoints and the frame path must fall back to defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset tx_valid", tx_valid, 1'b0);
    presetn <= 1'b1;
    apb(1'b0, 12'h100, 32'h0);
    chk("reset ctrl", rd, 32'h8081);
    apb(1'b0, 12'h000, 32'h0);
    chk("reset msg", rd, 32'hFE06FF00);
    apb(1'b0, 12'h004, 32'h0);
    chk("reset rate", rd, 32'h3E8);
    test_done();
  end
endmodule
`default_nettype wire
